// *** verilog/i2cmb_pkg.sv ***
// Constants for the I2C register, match and byte-buffer block.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
package i2cmb_pkg;

  // Register byte offsets
  localparam logic [7:0] OFFSET_CONTROL   = 8'h04;
  localparam logic [7:0] OFFSET_PRIMARY   = 8'h08;
  localparam logic [7:0] OFFSET_SECONDARY = 8'h0C;
  localparam logic [7:0] OFFSET_BUFFER    = 8'h10;
  localparam logic [7:0] OFFSET_STATUS    = 8'h18;

  // Reset values
  localparam logic [15:0] RESET_CONTROL   = 16'h0000;
  localparam logic [15:0] RESET_PRIMARY   = 16'h0000;
  localparam logic [15:0] RESET_SECONDARY = 16'h0000;
  localparam logic [7:0]  RESET_BUFFER    = 8'h00;

  // Bits that hold state; the rest read back as zero
  localparam logic [15:0] MASK_CONTROL   = 16'h1F3F;
  localparam logic [15:0] MASK_PRIMARY   = 16'hC3FF;
  localparam logic [15:0] MASK_SECONDARY = 16'h00FF;

  // Control register fields
  localparam int unsigned BIT_FINAL_MARK = 12;
  localparam int unsigned BIT_REQ_ENABLE = 11;
  localparam int unsigned BIT_BUF_IRQ    = 10;
  localparam int unsigned BIT_EVT_IRQ    = 9;
  localparam int unsigned BIT_ERR_IRQ    = 8;
  localparam int unsigned MHZ_MSB        = 5;

  // Valid bus clock codes
  localparam logic [5:0] MHZ_MIN = 6'h02;
  localparam logic [5:0] MHZ_MAX = 6'h24;

  // Primary and secondary match fields
  localparam int unsigned BIT_WIDTH_SELECT = 15;
  localparam int unsigned BIT_DUAL_ENABLE  = 0;

  // Status register fields
  localparam int unsigned BIT_ST_TX_EMPTY  = 0;
  localparam int unsigned BIT_ST_RX_FULL   = 1;
  localparam int unsigned BIT_ST_TIMING    = 2;
  localparam int unsigned BIT_ST_LAST_NACK = 3;
  localparam int unsigned BIT_ST_EVT_IRQ   = 4;
  localparam int unsigned BIT_ST_ERR_IRQ   = 5;

endpackage : i2cmb_pkg

// *** verilog/i2cmb_pulse_sync.sv ***
// Carries a one-cycle event from one clock domain to another.
// Assumes events are spaced at least three destination cycles apart.
`timescale 1ns/100ps
module i2cmb_pulse_sync
(
  input  wire logic src_clk,
  input  wire logic dst_clk,
  input  wire logic rst_n,
  input  wire logic src_pulse,
  output logic      dst_pulse
);

  logic src_toggle;
  logic sync_first;
  logic sync_second;
  logic sync_prev;

  always_ff @(posedge src_clk or negedge rst_n)
  begin
    if (!rst_n)
      src_toggle <= 1'b0;
    else if (src_pulse)
      src_toggle <= ~src_toggle;
  end

  // First stage is read only by the second
  always_ff @(posedge dst_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
      sync_prev   <= 1'b0;
    end
    else
    begin
      sync_first  <= src_toggle;
      sync_second <= sync_first;
      sync_prev   <= sync_second;
    end
  end

  assign dst_pulse = sync_second ^ sync_prev;

endmodule : i2cmb_pulse_sync

// *** verilog/i2cmb_addr_match.sv ***
// Own-address comparator on the link clock.
// Assumes its configuration inputs are already synchronised to link_clk.
`timescale 1ns/100ps
module i2cmb_addr_match
(
  input  wire logic       link_clk,
  input  wire logic       rst_n,
  input  wire logic       width_select,
  input  wire logic [9:0] primary_value,
  input  wire logic [6:0] second_value,
  input  wire logic       dual_enable,
  input  wire logic       addr_valid,
  input  wire logic [9:0] addr,
  input  wire logic       addr_is_10bit,
  output logic            match_hit
);

  logic hit_seven;
  logic hit_ten;

  // Seven-bit mode looks at bits 7:1 only
  assign hit_seven = !width_select && !addr_is_10bit &&
                     ((addr[6:0] == primary_value[7:1]) ||
                      (dual_enable &&
                       addr[6:0] == second_value));
  // Dual matching is ignored in ten-bit mode
  assign hit_ten = width_select && addr_is_10bit &&
                   (addr == primary_value);

  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      match_hit <= 1'b0;
    else
      match_hit <= addr_valid && (hit_seven || hit_ten);
  end

endmodule : i2cmb_addr_match

// *** verilog/i2cmb_regs.sv ***
// APB register block of the I2C interface: control, own-address match
// and byte buffer, with the link-side byte and address handling.
// Assumes status flags and end_of_transfer come from pclk logic, and
// that the link engine spaces bytes far apart compared to pclk.
//
// Function
// - Request enable raises transfer requests; final mark makes next end NACK.
// - Buffer flags raise event interrupt only with buffer and event enables.
// - Event interrupt on start, match, header, stop or byte done.
// - Error interrupt on any of seven error flags when enabled.
// - Clock code 2 to 36 enables timing; other codes disable it.
// - Width select picks seven-bit or ten-bit own-address matching.
// - Seven-bit mode compares only primary bits 7:1.
// - Dual enable also matches the secondary seven-bit value.
// - One byte buffer: writes load transmit byte, reads give received.
// - Received address bytes never enter the byte buffer.
// - Buffer writes are taken even while transmit empty is low.
// - Byte received when arbitration is lost at acknowledge is dropped.
`timescale 1ns/100ps
module i2cmb_regs
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        start_sent_flag,
  input  wire logic        match_flag,
  input  wire logic        header10_sent_flag,
  input  wire logic        stop_seen_flag,
  input  wire logic        byte_done_flag,
  input  wire logic        bus_error_flag,
  input  wire logic        arbitration_lost_flag,
  input  wire logic        ack_failure_flag,
  input  wire logic        overrun_flag,
  input  wire logic        packet_check_error_flag,
  input  wire logic        timeout_flag,
  input  wire logic        alert_flag,
  input  wire logic        end_of_transfer,
  output logic             event_irq,
  output logic             error_irq,
  output logic             dma_tx_request,
  output logic             dma_rx_request,
  output logic             last_byte_nack,
  output logic             timing_enable,
  output logic      [5:0]  bus_clock_mhz,
  output logic             transmit_empty_flag,
  output logic             receive_full_flag,
  input  wire logic        link_clk,
  input  wire logic        link_addr_valid,
  input  wire logic [9:0]  link_addr,
  input  wire logic        link_addr_is_10bit,
  output logic             link_match_hit,
  input  wire logic        link_rx_valid,
  input  wire logic [7:0]  link_rx_byte,
  input  wire logic        link_rx_is_address,
  input  wire logic        link_rx_arb_lost,
  input  wire logic        link_tx_take,
  output logic      [7:0]  link_tx_byte,
  output logic             link_tx_loaded
);

  logic [15:0] interrupt_dma_clock_control;
  logic [15:0] own_match_primary;
  logic [15:0] own_match_secondary;
  logic [7:0]  rx_buffer;
  logic [7:0]  tx_buffer;

  logic        access;
  logic        wr_access;
  logic        rd_access;
  logic        mapped;
  logic [31:0] next_prdata;

  logic [7:0]  link_rx_hold;
  logic        link_rx_accept;
  logic        rx_arrived;
  logic        tx_written;
  logic        tx_loaded_event;
  logic        tx_taken;
  logic [18:0] cfg_sync_first;
  logic [18:0] cfg_sync_second;

  logic final_mark;
  logic req_enable;
  logic buf_irq_en;
  logic evt_irq_en;
  logic err_irq_en;
  logic next_event_irq;
  logic next_error_irq;

  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] offset);
    reg_hit = (addr[7:2] == offset[7:2]);
  endfunction : reg_hit

  assign final_mark = interrupt_dma_clock_control[i2cmb_pkg::BIT_FINAL_MARK];
  assign req_enable = interrupt_dma_clock_control[i2cmb_pkg::BIT_REQ_ENABLE];
  assign buf_irq_en = interrupt_dma_clock_control[i2cmb_pkg::BIT_BUF_IRQ];
  assign evt_irq_en = interrupt_dma_clock_control[i2cmb_pkg::BIT_EVT_IRQ];
  assign err_irq_en = interrupt_dma_clock_control[i2cmb_pkg::BIT_ERR_IRQ];

  // APB: no wait states, a single access cycle
  assign access    = psel && penable;
  assign wr_access = access && pwrite;
  assign rd_access = access && !pwrite;
  assign pready    = 1'b1;
  assign mapped    = reg_hit(paddr, i2cmb_pkg::OFFSET_CONTROL) ||
                     reg_hit(paddr, i2cmb_pkg::OFFSET_PRIMARY) ||
                     reg_hit(paddr, i2cmb_pkg::OFFSET_SECONDARY) ||
                     reg_hit(paddr, i2cmb_pkg::OFFSET_BUFFER) ||
                     reg_hit(paddr, i2cmb_pkg::OFFSET_STATUS);
  // Unmapped addresses answer with an error and read zero
  assign pslverr   = access && !mapped;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      interrupt_dma_clock_control <= i2cmb_pkg::RESET_CONTROL;
    else if (wr_access && reg_hit(paddr, i2cmb_pkg::OFFSET_CONTROL))
      interrupt_dma_clock_control <= pwdata[15:0] &
                                     i2cmb_pkg::MASK_CONTROL;

  // Bit 14 is stored as written so software sees what it wrote
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      own_match_primary <= i2cmb_pkg::RESET_PRIMARY;
    else if (wr_access && reg_hit(paddr, i2cmb_pkg::OFFSET_PRIMARY))
      own_match_primary <= pwdata[15:0] & i2cmb_pkg::MASK_PRIMARY;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      own_match_secondary <= i2cmb_pkg::RESET_SECONDARY;
    else if (wr_access && reg_hit(paddr, i2cmb_pkg::OFFSET_SECONDARY))
      own_match_secondary <= pwdata[15:0] & i2cmb_pkg::MASK_SECONDARY;

  assign bus_clock_mhz = interrupt_dma_clock_control[i2cmb_pkg::MHZ_MSB:0];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timing_enable <= 1'b0;
    else
      timing_enable <= (bus_clock_mhz >= i2cmb_pkg::MHZ_MIN) &&
                       (bus_clock_mhz <= i2cmb_pkg::MHZ_MAX);
  end

  // Transmit side; a write is never refused
  assign tx_written = wr_access && reg_hit(paddr, i2cmb_pkg::OFFSET_BUFFER);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tx_buffer <= i2cmb_pkg::RESET_BUFFER;
    else if (tx_written)
      tx_buffer <= pwdata[7:0];

  // Empty flag: a take from the link wins over a same-cycle write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      transmit_empty_flag <= 1'b0;
    else if (tx_taken)
      transmit_empty_flag <= 1'b1;
    else if (tx_written)
      transmit_empty_flag <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      rx_buffer <= i2cmb_pkg::RESET_BUFFER;
    else if (rx_arrived)
      rx_buffer <= link_rx_hold;

  // A new byte wins over a read that clears the flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      receive_full_flag <= 1'b0;
    else if (rx_arrived)
      receive_full_flag <= 1'b1;
    else if (rd_access && reg_hit(paddr, i2cmb_pkg::OFFSET_BUFFER))
      receive_full_flag <= 1'b0;
  end

  // Transfer requests follow the buffer flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_tx_request <= 1'b0;
      dma_rx_request <= 1'b0;
    end
    else
    begin
      dma_tx_request <= req_enable && transmit_empty_flag;
      dma_rx_request <= req_enable && receive_full_flag;
    end
  end

  // Final mark arms a NACK for the closing byte; it ends on the next
  // received byte or when software rewrites the control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_byte_nack <= 1'b0;
    else if (end_of_transfer && final_mark)
      last_byte_nack <= 1'b1;
    else if (rx_arrived ||
             (wr_access && reg_hit(paddr, i2cmb_pkg::OFFSET_CONTROL)))
      last_byte_nack <= 1'b0;
  end

  always_comb
  begin
    next_event_irq = evt_irq_en &&
                     (start_sent_flag || match_flag ||
                      header10_sent_flag || stop_seen_flag ||
                      byte_done_flag ||
                      (buf_irq_en &&
                       (transmit_empty_flag || receive_full_flag)));
    next_error_irq = err_irq_en &&
                     (bus_error_flag || arbitration_lost_flag ||
                      ack_failure_flag || overrun_flag ||
                      packet_check_error_flag || timeout_flag ||
                      alert_flag);
  end

  // Held as levels, no latching: they fall once the sources do
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      event_irq <= 1'b0;
      error_irq <= 1'b0;
    end
    else
    begin
      event_irq <= next_event_irq;
      error_irq <= next_error_irq;
    end
  end

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (reg_hit(paddr, i2cmb_pkg::OFFSET_CONTROL))
      next_prdata[15:0] = interrupt_dma_clock_control;
    else if (reg_hit(paddr, i2cmb_pkg::OFFSET_PRIMARY))
      next_prdata[15:0] = own_match_primary;
    else if (reg_hit(paddr, i2cmb_pkg::OFFSET_SECONDARY))
      next_prdata[15:0] = own_match_secondary;
    else if (reg_hit(paddr, i2cmb_pkg::OFFSET_BUFFER))
      next_prdata[7:0] = rx_buffer;
    else if (reg_hit(paddr, i2cmb_pkg::OFFSET_STATUS))
    begin
      next_prdata[i2cmb_pkg::BIT_ST_TX_EMPTY]  = transmit_empty_flag;
      next_prdata[i2cmb_pkg::BIT_ST_RX_FULL]   = receive_full_flag;
      next_prdata[i2cmb_pkg::BIT_ST_TIMING]    = timing_enable;
      next_prdata[i2cmb_pkg::BIT_ST_LAST_NACK] = last_byte_nack;
      next_prdata[i2cmb_pkg::BIT_ST_EVT_IRQ]   = event_irq;
      next_prdata[i2cmb_pkg::BIT_ST_ERR_IRQ]   = error_irq;
    end
  end

  // Read data is registered at the setup phase so it stands in access
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= next_prdata;

  // Link side: match configuration is quasi-static, so per-bit
  // two-stage synchronisers suffice; software changes it only idle
  always_ff @(posedge link_clk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_sync_first  <= 19'h00000;
      cfg_sync_second <= 19'h00000;
    end
    else
    begin
      cfg_sync_first  <= {own_match_primary[i2cmb_pkg::BIT_WIDTH_SELECT],
                          own_match_primary[9:0],
                          own_match_secondary[7:1],
                          own_match_secondary[i2cmb_pkg::BIT_DUAL_ENABLE]};
      cfg_sync_second <= cfg_sync_first;
    end
  end

  i2cmb_addr_match u_match
  (
    .link_clk      (link_clk),
    .rst_n         (presetn),
    .width_select  (cfg_sync_second[18]),
    .primary_value (cfg_sync_second[17:8]),
    .second_value  (cfg_sync_second[7:1]),
    .dual_enable   (cfg_sync_second[0]),
    .addr_valid    (link_addr_valid),
    .addr          (link_addr),
    .addr_is_10bit (link_addr_is_10bit),
    .match_hit     (link_match_hit)
  );

  // Address bytes and bytes lost at the acknowledge never reach software
  assign link_rx_accept = link_rx_valid && !link_rx_is_address &&
                          !link_rx_arb_lost;

  // Hold stays stable until the next accepted byte, well after pclk
  // has copied it
  always_ff @(posedge link_clk or negedge presetn)
    if (!presetn)
      link_rx_hold <= 8'h00;
    else if (link_rx_accept)
      link_rx_hold <= link_rx_byte;

  i2cmb_pulse_sync u_rx_sync
  (
    .src_clk   (link_clk),
    .dst_clk   (pclk),
    .rst_n     (presetn),
    .src_pulse (link_rx_accept),
    .dst_pulse (rx_arrived)
  );

  i2cmb_pulse_sync u_tx_sync
  (
    .src_clk   (pclk),
    .dst_clk   (link_clk),
    .rst_n     (presetn),
    .src_pulse (tx_written),
    .dst_pulse (tx_loaded_event)
  );

  i2cmb_pulse_sync u_take_sync
  (
    .src_clk   (link_clk),
    .dst_clk   (pclk),
    .rst_n     (presetn),
    .src_pulse (link_tx_take),
    .dst_pulse (tx_taken)
  );

  // tx_buffer is stable for several link cycles before the event lands
  always_ff @(posedge link_clk or negedge presetn)
    if (!presetn)
      link_tx_byte <= 8'h00;
    else if (tx_loaded_event)
      link_tx_byte <= tx_buffer;

  always_ff @(posedge link_clk or negedge presetn)
  begin
    if (!presetn)
      link_tx_loaded <= 1'b0;
    else if (tx_loaded_event)
      link_tx_loaded <= 1'b1;
    else if (link_tx_take)
      link_tx_loaded <= 1'b0;
  end

endmodule : i2cmb_regs

// *** dv/i2cmb_regs_monitor.sv ***
// Checker for the I2C register block, bound to its top module.
// Assumes only the top module's ports are visible; shadows writes.
`timescale 1ns/100ps
module i2cmb_regs_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        start_sent_flag,
  input wire logic        match_flag,
  input wire logic        header10_sent_flag,
  input wire logic        stop_seen_flag,
  input wire logic        byte_done_flag,
  input wire logic        bus_error_flag,
  input wire logic        arbitration_lost_flag,
  input wire logic        ack_failure_flag,
  input wire logic        overrun_flag,
  input wire logic        packet_check_error_flag,
  input wire logic        timeout_flag,
  input wire logic        alert_flag,
  input wire logic        end_of_transfer,
  input wire logic        event_irq,
  input wire logic        error_irq,
  input wire logic        dma_tx_request,
  input wire logic        dma_rx_request,
  input wire logic        last_byte_nack,
  input wire logic        timing_enable,
  input wire logic [5:0]  bus_clock_mhz,
  input wire logic        transmit_empty_flag,
  input wire logic        receive_full_flag,
  input wire logic        link_clk,
  input wire logic        link_addr_valid,
  input wire logic [9:0]  link_addr,
  input wire logic        link_addr_is_10bit,
  input wire logic        link_match_hit
);
  logic [15:0] ctl;
  logic [15:0] prim;
  logic [15:0] sec;
  wire         wr = psel && penable && pwrite;
  wire         evt_src = start_sent_flag | match_flag | header10_sent_flag
    | stop_seen_flag | byte_done_flag
    | (ctl[10] & (transmit_empty_flag | receive_full_flag));
  wire         err_src = bus_error_flag | arbitration_lost_flag
    | ack_failure_flag | overrun_flag | packet_check_error_flag
    | timeout_flag | alert_flag;

  // Shadows of the written fields
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctl <= 16'h0000;
    else if (wr && paddr == 8'h04)
      ctl <= pwdata[15:0];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prim <= 16'h0000;
    else if (wr && paddr == 8'h08)
      prim <= pwdata[15:0];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      sec <= 16'h0000;
    else if (wr && paddr == 8'h0C)
      sec <= pwdata[15:0];

  property p_evt;
    @(posedge pclk) disable iff (!presetn)
      event_irq == $past(ctl[9] && evt_src);
  endproperty
  a_evt: assert property (p_evt)
    else $error("event irq wrong");
  property p_err;
    @(posedge pclk) disable iff (!presetn)
      error_irq == $past(ctl[8] && err_src);
  endproperty
  a_err: assert property (p_err)
    else $error("error irq wrong");
  property p_dma;
    @(posedge pclk) disable iff (!presetn)
      {dma_tx_request, dma_rx_request} ==
        $past({ctl[11] && transmit_empty_flag, ctl[11] && receive_full_flag});
  endproperty
  a_dma: assert property (p_dma)
    else $error("request wrong");
  property p_nack;
    @(posedge pclk) disable iff (!presetn)
      end_of_transfer && ctl[12] |=> last_byte_nack;
  endproperty
  a_nack: assert property (p_nack)
    else $error("nack not set");
  property p_clk;
    @(posedge pclk) disable iff (!presetn) bus_clock_mhz == ctl[5:0];
  endproperty
  a_clk: assert property (p_clk)
    else $error("clock code wrong");
  property p_tim;
    @(posedge pclk) disable iff (!presetn)
      $stable(bus_clock_mhz) |->
        timing_enable == (bus_clock_mhz >= 6'h02 && bus_clock_mhz <= 6'h24);
  endproperty
  a_tim: assert property (p_tim)
    else $error("timing enable wrong");
  property p_match7;
    @(posedge link_clk) disable iff (!presetn)
      link_addr_valid && !link_addr_is_10bit && !prim[15] &&
      (link_addr[6:0] == prim[7:1] || (sec[0] && link_addr[6:0] == sec[7:1]))
      |=> link_match_hit;
  endproperty
  a_match7: assert property (p_match7)
    else $error("7-bit match missed");
  property p_match10;
    @(posedge link_clk) disable iff (!presetn)
      link_addr_valid && link_addr_is_10bit && prim[15] &&
      link_addr == prim[9:0] |=> link_match_hit;
  endproperty
  a_match10: assert property (p_match10)
    else $error("10-bit match missed");
  property p_hit_cause;
    @(posedge link_clk) disable iff (!presetn)
      link_match_hit |-> $past(link_addr_valid);
  endproperty
  a_hit_cause: assert property (p_hit_cause)
    else $error("match without address");

  c_evt: cover property (@(posedge pclk) $rose(event_irq));
  c_err: cover property (@(posedge pclk) $rose(error_irq));
  c_hit: cover property (@(posedge link_clk) link_match_hit);
endmodule : i2cmb_regs_monitor

bind i2cmb_regs i2cmb_regs_monitor i_i2cmb_regs_monitor (.*);

// *** dv/i2cmb_link_model.sv ***
// Behavioural engine on the link side: addresses, bytes, takes.
// Assumes a free-running link clock; data lines invert when idle.
`timescale 1ns/100ps
module i2cmb_link_model
(
  input  wire logic link_clk,
  input  wire logic link_match_hit,
  output logic       link_addr_valid,
  output logic [9:0] link_addr,
  output logic       link_addr_is_10bit,
  output logic       link_rx_valid,
  output logic [7:0] link_rx_byte,
  output logic       link_rx_is_address,
  output logic       link_rx_arb_lost,
  output logic       link_tx_take
);
  int hits = 0;
  initial
  begin
    {link_addr_valid, link_rx_valid, link_tx_take} = 3'h0;
    {link_addr_is_10bit, link_rx_is_address, link_rx_arb_lost} = 3'h0;
    link_addr = 10'h000;
    link_rx_byte = 8'h00;
  end
  always @(posedge link_clk)
    if (link_match_hit)
      hits++;
  task send_addr(input logic [9:0] a, input logic ten);
    @(posedge link_clk);
    {link_addr_valid, link_addr, link_addr_is_10bit} <= {1'b1, a, ten};
    @(posedge link_clk);
    link_addr_valid <= 1'b0;
    link_addr <= ~a;
    repeat (3) @(posedge link_clk);
  endtask : send_addr
  // Address and lost-arbitration bytes are offered like data bytes
  task send_byte(input logic [7:0] b, input logic adr, input logic arb);
    @(posedge link_clk);
    {link_rx_valid, link_rx_byte} <= {1'b1, b};
    {link_rx_is_address, link_rx_arb_lost} <= {adr, arb};
    @(posedge link_clk);
    link_rx_valid <= 1'b0;
    @(posedge link_clk);
    link_rx_byte <= ~b;
  endtask : send_byte
  task take;
    @(posedge link_clk);
    link_tx_take <= 1'b1;
    @(posedge link_clk);
    link_tx_take <= 1'b0;
  endtask : take
endmodule : i2cmb_link_model

// *** dv/i2cmb_regs_test.sv ***
// Self-checking bench for the I2C register block over APB.
// Assumes the link model stands at the link ports.
`timescale 1ns/100ps
module i2cmb_regs_test;
  logic        pclk = 0, link_clk = 0, presetn = 0;
  logic        psel = 0, penable = 0, pwrite = 0, end_of_transfer = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [11:0] flg = 12'h000;
  logic        pready, pslverr, er, event_irq, error_irq, dma_tx_request;
  logic        dma_rx_request, last_byte_nack, timing_enable, link_tx_loaded;
  logic        transmit_empty_flag, receive_full_flag, link_match_hit;
  logic [5:0]  bus_clock_mhz;
  logic [7:0]  link_tx_byte, link_rx_byte;
  logic [9:0]  link_addr;
  logic        link_addr_valid, link_addr_is_10bit, link_rx_valid;
  logic        link_rx_is_address, link_rx_arb_lost, link_tx_take;
  wire         start_sent_flag, match_flag, header10_sent_flag;
  wire         stop_seen_flag, byte_done_flag, bus_error_flag;
  wire         arbitration_lost_flag, ack_failure_flag, overrun_flag;
  wire         packet_check_error_flag, timeout_flag, alert_flag;
  int          error_cnt = 0, num_checks = 0, cyc = 0;
  logic [7:0]  t_addr [4] = '{8'h04, 8'h08, 8'h0C, 8'h14};
  logic [31:0] t_exp [4] = '{32'h1F3F, 32'hC3FF, 32'h00FF, 32'h0};
  logic        t_err [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  logic [5:0]  c_code [6] = '{6'h00, 6'h01, 6'h02, 6'h24, 6'h25, 6'h3F};
  logic        c_tim [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  assign {start_sent_flag, match_flag, header10_sent_flag, stop_seen_flag,
    byte_done_flag, bus_error_flag, arbitration_lost_flag, ack_failure_flag,
    overrun_flag, packet_check_error_flag, timeout_flag, alert_flag} = flg;

  i2cmb_regs i_i2cmb_regs (.*);
  i2cmb_link_model i_i2cmb_link_model (.*);

  initial forever #12.5 pclk = ~pclk;
  initial
  begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      error_cnt++;
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick
  // Holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task probe(input logic [9:0] a, input logic ten, input int exp);
    int h;
    h = i_i2cmb_link_model.hits;
    i_i2cmb_link_model.send_addr(a, ten);
    chk(32'(i_i2cmb_link_model.hits - h), 32'(exp));
  endtask : probe

  always @(posedge pclk)
    if (++cyc == 20000)
    begin
      error_cnt++;
      end_sim;
    end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    tick(2);
    chk({event_irq, error_irq, last_byte_nack, link_tx_loaded}, 0);
    // Rows: reset value, stored bits, unmapped refusal
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, t_addr[i], 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, t_addr[i], 32'hFFFFFFFF);
      apb(1'b0, t_addr[i], 32'h0);
      chk(rd, t_exp[i]);
      chk(er, t_err[i]);
    end
    apb(1'b1, 8'h08, 32'h4000);
    apb(1'b1, 8'h0C, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, 8'h04, {26'h0, c_code[i]});
      tick(2);
      chk(timing_enable, c_tim[i]);
    end
    apb(1'b1, 8'h04, 32'h0300);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge pclk) flg <= 12'h001 << i;
      tick(3);
      chk({event_irq, error_irq}, i < 7 ? 2'b01 : 2'b10);
      @(posedge pclk) flg <= 12'h000;
      tick(2);
      chk({event_irq, error_irq}, 2'b00);
    end
    apb(1'b1, 8'h04, 32'h0);
    flg <= 12'hFFF;
    tick(3);
    chk({event_irq, error_irq}, 2'b00);
    @(posedge pclk) flg <= 12'h000;
    apb(1'b1, 8'h04, 32'h0E00);
    i_i2cmb_link_model.send_byte(8'h5A, 1'b1, 1'b0);
    tick(8);
    chk(receive_full_flag, 1'b0);
    i_i2cmb_link_model.send_byte(8'h3C, 1'b0, 1'b1);
    tick(8);
    chk(receive_full_flag, 1'b0);
    i_i2cmb_link_model.send_byte(8'hA5, 1'b0, 1'b0);
    tick(8);
    chk({receive_full_flag, event_irq, dma_rx_request}, 3'b111);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h00A5);
    tick(3);
    chk(receive_full_flag, 1'b0);
    apb(1'b1, 8'h10, 32'h0077);
    tick(8);
    chk({link_tx_loaded, link_tx_byte}, 9'h177);
    i_i2cmb_link_model.take();
    tick(8);
    chk({transmit_empty_flag, dma_tx_request, event_irq}, 3'b111);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h11);
    apb(1'b1, 8'h04, 32'h1000);
    end_of_transfer <= 1'b1;
    @(posedge pclk);
    end_of_transfer <= 1'b0;
    tick(1);
    chk(last_byte_nack, 1'b1);
    apb(1'b1, 8'h08, 32'h40A4);
    apb(1'b1, 8'h0C, 32'h0023);
    tick(10);
    probe(10'h352, 1'b0, 1);
    probe(10'h011, 1'b0, 1);
    probe(10'h053, 1'b0, 0);
    apb(1'b1, 8'h0C, 32'h0022);
    tick(10);
    probe(10'h011, 1'b0, 0);
    apb(1'b1, 8'h08, 32'hC2A4);
    tick(10);
    probe(10'h2A4, 1'b1, 1);
    probe(10'h052, 1'b0, 0);
    end_sim;
  end
endmodule : i2cmb_regs_test
